// >>> hw/cpx_cpu_sysregs.sv
`timescale 1ns/1ps
`include "cpx_params.svh"

module cpx_cpu_sysregs
	import cpx_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic io_dma,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata_ff,
	input wire logic mem_wr,
	input wire logic instr_retire,
	input wire logic exec_store,
	input wire logic exec_load,
	input wire logic exec_load_fuse,
	input wire logic exec_sleep,
	input wire logic prot_target,
	input wire logic lock_target,
	input wire logic fuse_lock,
	output logic guarded_wr_ok,
	output logic store_allow,
	output logic load_allow,
	output logic irq_hold,
	input wire logic wide_rd,
	input wire logic wide_wr,
	input wire cpx_bidx_t wide_byte,
	input wire cpx_bidx_t wide_top,
	input wire logic [31:0] wide_val,
	output logic wide_commit_ff,
	output logic [31:0] wide_wdata_ff,
	input wire logic [15:0] x_ptr,
	input wire logic [15:0] y_ptr,
	input wire logic [15:0] z_ptr,
	input wire logic [15:0] direct_operand,
	output logic [23:0] x_addr_ff,
	output logic [23:0] y_addr_ff,
	output logic [23:0] z_addr_ff,
	output logic [23:0] direct_addr_ff,
	output logic [23:0] pm_ext_addr_ff,
	output logic [23:0] pm_load_addr_ff,
	output logic [23:0] jump_addr_ff
);
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [23:0] join_ext(input logic [7:0] ext,
		input logic [15:0] ptr);
		join_ext = {ext, ptr};
	endfunction

	function automatic logic hit(input logic [7:0] addr,
		input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	logic [7:0] dext_ff;
	logic [7:0] xext_ff;
	logic [7:0] yext_ff;
	logic [7:0] zext_ff;
	logic [7:0] jext_ff;
	cpx_win_t win_ff;
	cpx_win_t nxt_win;
	logic [2:0] cnt_ff;
	logic [2:0] nxt_cnt;
	logic cpu_wr;
	logic key_wr;
	logic tmp_wr;
	logic io_open;
	logic pm_open;
	logic [7:0] tmp_byte;
	logic [7:0] wide_rbyte;
	cpx_bidx_t tmp_sel;

	assign cpu_wr = io_wr && !io_dma;
	assign key_wr = cpu_wr && hit(io_addr, `CPX_OFS_KEY);
	assign io_open = (win_ff == CPX_IO_OPEN);
	assign pm_open = (win_ff == CPX_PM_OPEN);
	assign tmp_wr = io_wr && !wide_wr && !wide_rd &&
		(hit(io_addr, `CPX_OFS_TMP0) || hit(io_addr, `CPX_OFS_TMP1) ||
		hit(io_addr, `CPX_OFS_TMP2));

	always_comb begin
		tmp_sel = 2'h3;
		if (hit(io_addr, `CPX_OFS_TMP0)) begin
			tmp_sel = 2'h0;
		end else if (hit(io_addr, `CPX_OFS_TMP1)) begin
			tmp_sel = 2'h1;
		end else if (hit(io_addr, `CPX_OFS_TMP2)) begin
			tmp_sel = 2'h2;
		end
	end

	// ****************************************************************
	// address extension registers
	// ****************************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dext_ff <= `CPX_EXT_RST;
			xext_ff <= `CPX_EXT_RST;
			yext_ff <= `CPX_EXT_RST;
			zext_ff <= `CPX_EXT_RST;
			jext_ff <= `CPX_EXT_RST;
		end else if (io_wr && !wide_wr) begin
			// only implemented bits are stored, the rest stay zero
			if (hit(io_addr, `CPX_OFS_DEXT)) begin
				dext_ff <= io_wdata & `CPX_DEXT_MASK;
			end
			if (hit(io_addr, `CPX_OFS_XEXT)) begin
				xext_ff <= io_wdata & `CPX_XEXT_MASK;
			end
			if (hit(io_addr, `CPX_OFS_YEXT)) begin
				yext_ff <= io_wdata & `CPX_YEXT_MASK;
			end
			if (hit(io_addr, `CPX_OFS_ZEXT)) begin
				zext_ff <= io_wdata & `CPX_ZEXT_MASK;
			end
			if (hit(io_addr, `CPX_OFS_JEXT)) begin
				jext_ff <= io_wdata & `CPX_JEXT_MASK;
			end
		end
	end

	// ****************************************************************
	// 24-bit address formation
	// ****************************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			x_addr_ff <= 24'h00_0000;
			y_addr_ff <= 24'h00_0000;
			z_addr_ff <= 24'h00_0000;
			direct_addr_ff <= 24'h00_0000;
			pm_ext_addr_ff <= 24'h00_0000;
			pm_load_addr_ff <= 24'h00_0000;
			jump_addr_ff <= 24'h00_0000;
		end else begin
			x_addr_ff <= join_ext(xext_ff, x_ptr);
			y_addr_ff <= join_ext(yext_ff, y_ptr);
			z_addr_ff <= join_ext(zext_ff, z_ptr);
			direct_addr_ff <= join_ext(dext_ff, direct_operand);
			pm_ext_addr_ff <= join_ext(zext_ff, z_ptr);
			pm_load_addr_ff <= join_ext(8'h00, z_ptr);
			jump_addr_ff <= join_ext(jext_ff, z_ptr);
		end
	end

	// ****************************************************************
	// change protection window
	// ****************************************************************
	always_comb begin
		nxt_win = win_ff;
		nxt_cnt = cnt_ff;
		if (instr_retire && cnt_ff != 3'h0) begin
			nxt_cnt = cnt_ff - 3'h1;
			if (cnt_ff == 3'h1) begin
				nxt_win = CPX_IDLE;
			end
		end
		case (win_ff)
		CPX_IO_OPEN: begin
			if (cpu_wr || mem_wr || exec_store || exec_load ||
				exec_sleep) begin
				nxt_win = CPX_IDLE;
			end
		end
		CPX_PM_OPEN: begin
			if (cpu_wr || mem_wr || exec_sleep) begin
				nxt_win = CPX_IDLE;
			end
		end
		CPX_IDLE: begin
			nxt_win = CPX_IDLE;
		end
		default: begin
			nxt_win = CPX_IDLE;
		end
		endcase
		if (nxt_win == CPX_IDLE) begin
			nxt_cnt = 3'h0;
		end
		// a fresh signature wins over any close in the same cycle
		if (key_wr && io_wdata == `CPX_SIG_IO) begin
			nxt_win = CPX_IO_OPEN;
			nxt_cnt = `CPX_WIN_INSTR;
		end else if (key_wr && io_wdata == `CPX_SIG_PMEM) begin
			nxt_win = CPX_PM_OPEN;
			nxt_cnt = `CPX_WIN_INSTR;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			win_ff <= CPX_IDLE;
			cnt_ff <= 3'h0;
		end else begin
			win_ff <= nxt_win;
			cnt_ff <= nxt_cnt;
		end
	end

	// ****************************************************************
	// gating of protected actions
	// ****************************************************************
	assign irq_hold = (win_ff != CPX_IDLE);
	assign store_allow = exec_store && pm_open;
	assign load_allow = exec_load && (!exec_load_fuse || pm_open);
	assign guarded_wr_ok = io_wr && !(lock_target && fuse_lock) &&
		(!prot_target || (cpu_wr && io_open));

	// ****************************************************************
	// multi-byte access temporaries
	// ****************************************************************
	cpx_temp_bank u_temp (
		.clk(clk),
		.sys_rst(sys_rst),
		.wide_rd(wide_rd),
		.wide_wr(wide_wr),
		.wide_byte(wide_byte),
		.wide_top(wide_top),
		.wide_val(wide_val),
		.wdata(io_wdata),
		.tmp_wr(tmp_wr),
		.tmp_sel(tmp_sel),
		.tmp_byte(tmp_byte),
		.wide_rbyte(wide_rbyte),
		.wide_commit_ff(wide_commit_ff),
		.wide_wdata_ff(wide_wdata_ff)
	);

	// ****************************************************************
	// read data
	// ****************************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			io_rdata_ff <= 8'h00;
		end else if (wide_rd) begin
			io_rdata_ff <= wide_rbyte;
		end else if (io_rd) begin
			case (io_addr)
			`CPX_OFS_KEY: io_rdata_ff <= {6'h00, pm_open, io_open};
			`CPX_OFS_DEXT: io_rdata_ff <= dext_ff;
			`CPX_OFS_XEXT: io_rdata_ff <= xext_ff;
			`CPX_OFS_YEXT: io_rdata_ff <= yext_ff;
			`CPX_OFS_ZEXT: io_rdata_ff <= zext_ff;
			`CPX_OFS_JEXT: io_rdata_ff <= jext_ff;
			`CPX_OFS_TMP0, `CPX_OFS_TMP1, `CPX_OFS_TMP2: begin
				io_rdata_ff <= tmp_byte;
			end
			default: io_rdata_ff <= 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	a_io_sig_opens: assert property (
		@(posedge clk) disable iff (sys_rst)
		key_wr && io_wdata == `CPX_SIG_IO |=> io_open && cnt_ff == 3'h4)
		else $error("io signature did not open window");

	a_pm_sig_opens: assert property (
		@(posedge clk) disable iff (sys_rst)
		key_wr && io_wdata == `CPX_SIG_PMEM |=> pm_open)
		else $error("pmem signature did not open window");

	a_win_max_four: assert property (
		@(posedge clk) disable iff (sys_rst)
		(win_ff != CPX_IDLE) |-> cnt_ff != 3'h0 && cnt_ff <= 3'h4)
		else $error("window open without instruction budget");

	a_io_close_wr: assert property (
		@(posedge clk) disable iff (sys_rst)
		io_open && (cpu_wr || mem_wr || exec_store || exec_load ||
		exec_sleep) && !key_wr |=> win_ff == CPX_IDLE)
		else $error("io window stayed open after closing event");

	a_pm_close: assert property (
		@(posedge clk) disable iff (sys_rst)
		pm_open && (mem_wr || exec_sleep) && !key_wr |=>
		win_ff == CPX_IDLE)
		else $error("pmem window stayed open after closing event");

	a_irq_held: assert property (
		@(posedge clk) disable iff (sys_rst)
		key_wr && io_wdata == `CPX_SIG_IO ##1 (!instr_retire && !cpu_wr &&
		!mem_wr && !exec_store && !exec_load && !exec_sleep) [*3] |->
		irq_hold)
		else $error("interrupts not held in window");

	a_dma_no_open: assert property (
		@(posedge clk) disable iff (sys_rst)
		win_ff == CPX_IDLE && io_wr && io_dma |=> win_ff == CPX_IDLE)
		else $error("dma write opened a window");

	a_dma_keeps_win: assert property (
		@(posedge clk) disable iff (sys_rst)
		win_ff != CPX_IDLE && io_wr && io_dma && !mem_wr &&
		!instr_retire && !exec_store && !exec_load && !exec_sleep |=>
		win_ff == $past(win_ff) && cnt_ff == $past(cnt_ff))
		else $error("dma write changed the window");

	a_key_readback: assert property (
		@(posedge clk) disable iff (sys_rst)
		io_rd && !wide_rd && hit(io_addr, `CPX_OFS_KEY) |=>
		io_rdata_ff == {6'h00, $past(pm_open), $past(io_open)})
		else $error("key register read back wrong");

	a_store_gated: assert property (
		@(posedge clk) disable iff (sys_rst)
		store_allow |-> pm_open && exec_store)
		else $error("store allowed without pmem window");

	a_fuse_blocks: assert property (
		@(posedge clk) disable iff (sys_rst)
		fuse_lock && lock_target |-> !guarded_wr_ok)
		else $error("locked register write let through");

	a_ext_zero_bits: assert property (
		@(posedge clk) disable iff (sys_rst)
		(jext_ff & ~`CPX_JEXT_MASK) == 8'h00 &&
		(dext_ff & ~`CPX_DEXT_MASK) == 8'h00)
		else $error("unimplemented extension bit set");

	a_jump_addr: assert property (
		@(posedge clk) disable iff (sys_rst)
		1'b1 |=> jump_addr_ff == {$past(jext_ff), $past(z_ptr)})
		else $error("jump address not formed from extension");

	a_direct_addr: assert property (
		@(posedge clk) disable iff (sys_rst)
		1'b1 |=> direct_addr_ff == {$past(dext_ff), $past(direct_operand)})
		else $error("direct address not formed from extension");

	a_pm_load_plain: assert property (
		@(posedge clk) disable iff (sys_rst)
		1'b1 |=> pm_load_addr_ff == {8'h00, $past(z_ptr)})
		else $error("plain load address used an extension");
endmodule // cpx_cpu_sysregs

// >>> hw/cpx_params.svh
`ifndef CPX_PARAMS_SVH
`define CPX_PARAMS_SVH

// ****************************************************************
// register offsets on the cpu i/o port
// ****************************************************************
`define CPX_OFS_KEY 8'h04
`define CPX_OFS_DEXT 8'h08
`define CPX_OFS_XEXT 8'h09
`define CPX_OFS_YEXT 8'h0A
`define CPX_OFS_ZEXT 8'h0B
`define CPX_OFS_JEXT 8'h0C
`define CPX_OFS_TMP0 8'h10
`define CPX_OFS_TMP1 8'h11
`define CPX_OFS_TMP2 8'h12

// ****************************************************************
// implemented extension bits, reset values
// ****************************************************************
`define CPX_DEXT_MASK 8'h0F
`define CPX_XEXT_MASK 8'h0F
`define CPX_YEXT_MASK 8'h0F
`define CPX_ZEXT_MASK 8'h0F
`define CPX_JEXT_MASK 8'h03
`define CPX_EXT_RST 8'h00
`define CPX_TMP_RST 8'h00

// ****************************************************************
// change protection
// ****************************************************************
`define CPX_SIG_PMEM 8'h9D
`define CPX_SIG_IO 8'hD8
`define CPX_KEY_IO_BIT 0
`define CPX_KEY_PM_BIT 1
`define CPX_WIN_INSTR 3'h4

`endif

// >>> hw/cpx_pkg.sv
package cpx_pkg;
	// gray along idle -> io -> pmem
	typedef enum logic [1:0] {
		CPX_IDLE = 2'b00,
		CPX_IO_OPEN = 2'b01,
		CPX_PM_OPEN = 2'b11
	} cpx_win_t;

	// byte index within a multi-byte register, from 0 up to its width in bytes minus one
	typedef logic [1:0] cpx_bidx_t;
endpackage

// >>> hw/cpx_temp_bank.sv
`timescale 1ns/1ps
`include "cpx_params.svh"

// ****************************************************************
// shared temporary bytes for atomic multi-byte access
// ****************************************************************
module cpx_temp_bank
	import cpx_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wide_rd,
	input wire logic wide_wr,
	input wire cpx_bidx_t wide_byte,
	input wire cpx_bidx_t wide_top,
	input wire logic [31:0] wide_val,
	input wire logic [7:0] wdata,
	input wire logic tmp_wr,
	input wire cpx_bidx_t tmp_sel,
	output logic [7:0] tmp_byte,
	output logic [7:0] wide_rbyte,
	output logic wide_commit_ff,
	output logic [31:0] wide_wdata_ff
);
	logic [7:0] tmp_ff [0:2];
	logic commit;

	assign commit = wide_wr && (wide_byte == wide_top);
	assign tmp_byte = (tmp_sel == 2'h3) ? 8'h00 : tmp_ff[tmp_sel];
	assign wide_rbyte = (wide_byte == 2'h0) ? wide_val[7:0] :
		tmp_ff[wide_byte - 2'h1];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 3; i++) begin
				tmp_ff[i] <= `CPX_TMP_RST;
			end
		end else if (wide_rd && wide_byte == 2'h0) begin
			// low byte read snapshots all upper bytes at once
			tmp_ff[0] <= wide_val[15:8];
			tmp_ff[1] <= wide_val[23:16];
			tmp_ff[2] <= wide_val[31:24];
		end else if (wide_wr && !commit) begin
			tmp_ff[wide_byte] <= wdata;
		end else if (tmp_wr && tmp_sel != 2'h3) begin
			tmp_ff[tmp_sel] <= wdata;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wide_commit_ff <= 1'b0;
			wide_wdata_ff <= 32'h0000_0000;
		end else begin
			wide_commit_ff <= commit;
			if (commit) begin
				// top byte joins the buffered lower bytes in one step
				case (wide_top)
				2'h0: wide_wdata_ff <= {24'h00_0000, wdata};
				2'h1: wide_wdata_ff <= {16'h0000, wdata, tmp_ff[0]};
				2'h2: wide_wdata_ff <= {8'h00, wdata, tmp_ff[1],
					tmp_ff[0]};
				default: wide_wdata_ff <= {wdata, tmp_ff[2], tmp_ff[1],
					tmp_ff[0]};
				endcase
			end
		end
	end

	a_low_write_held: assert property (
		@(posedge clk) disable iff (sys_rst)
		wide_wr && wide_byte == 2'h0 && wide_top != 2'h0 ##1
		wide_wr && wide_byte == wide_top && wide_top == 2'h1 |=>
		wide_commit_ff && wide_wdata_ff[7:0] == $past(wdata, 2))
		else $error("low byte lost on wide write");

	a_high_read_snap: assert property (
		@(posedge clk) disable iff (sys_rst)
		wide_rd && wide_byte == 2'h0 && !wide_wr && !tmp_wr |=>
		tmp_ff[0] == $past(wide_val[15:8]))
		else $error("high byte not snapshotted on low read");
endmodule // cpx_temp_bank

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`include "cpx_params.svh"

module testbench
	import cpx_pkg::*;
;
	logic clk, sys_rst, io_wr, io_rd, io_dma, mem_wr, instr_retire;
	logic exec_store, exec_load, exec_load_fuse, exec_sleep;
	logic prot_target, lock_target, fuse_lock, wide_rd, wide_wr;
	logic guarded_wr_ok, store_allow, load_allow, irq_hold, wide_commit_ff;
	logic [7:0] io_addr, io_wdata, io_rdata_ff;
	cpx_bidx_t wide_byte, wide_top;
	logic [31:0] wide_val, wide_wdata_ff;
	logic [15:0] x_ptr, y_ptr, z_ptr, direct_operand;
	logic [23:0] x_addr_ff, y_addr_ff, z_addr_ff, direct_addr_ff;
	logic [23:0] pm_ext_addr_ff, pm_load_addr_ff, jump_addr_ff;
	logic g_ok, s_al, l_al;
	int bad_count = 0;
	int check_count = 0;
	logic [7:0] ofs [9] = '{`CPX_OFS_KEY, `CPX_OFS_DEXT, `CPX_OFS_XEXT,
		`CPX_OFS_YEXT, `CPX_OFS_ZEXT, `CPX_OFS_JEXT, `CPX_OFS_TMP0,
		`CPX_OFS_TMP1, `CPX_OFS_TMP2};
	logic [7:0] ext_wv [5] = '{8'hF1, 8'h52, 8'h33, 8'h0C, 8'hFE};
	logic [7:0] ext_ev [5] = '{8'h01, 8'h02, 8'h03, 8'h0C, 8'h02};
	logic [5:0] io_cl [4] = '{6'h20, 6'h08, 6'h04, 6'h01};

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	cpx_cpu_sysregs u_cpx_cpu_sysregs (.clk(clk), .sys_rst(sys_rst),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_dma(io_dma),
		.io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff), .mem_wr(mem_wr),
		.instr_retire(instr_retire), .exec_store(exec_store),
		.exec_load(exec_load), .exec_load_fuse(exec_load_fuse),
		.exec_sleep(exec_sleep), .prot_target(prot_target),
		.lock_target(lock_target), .fuse_lock(fuse_lock),
		.guarded_wr_ok(guarded_wr_ok), .store_allow(store_allow),
		.load_allow(load_allow), .irq_hold(irq_hold), .wide_rd(wide_rd),
		.wide_wr(wide_wr), .wide_byte(wide_byte), .wide_top(wide_top),
		.wide_val(wide_val), .wide_commit_ff(wide_commit_ff),
		.wide_wdata_ff(wide_wdata_ff), .x_ptr(x_ptr), .y_ptr(y_ptr),
		.z_ptr(z_ptr), .direct_operand(direct_operand),
		.x_addr_ff(x_addr_ff), .y_addr_ff(y_addr_ff), .z_addr_ff(z_addr_ff),
		.direct_addr_ff(direct_addr_ff), .pm_ext_addr_ff(pm_ext_addr_ff),
		.pm_load_addr_ff(pm_load_addr_ff), .jump_addr_ff(jump_addr_ff));

	// ****************************************************************
	// access tasks
	// ****************************************************************
	task chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// guarded_wr_ok is sampled inside the write cycle
	task wr(input logic [7:0] a, input logic [7:0] d, input logic dma,
		input logic prot, input logic lock);
		@(negedge clk);
		io_wr = 1'b1;
		io_addr = a;
		io_wdata = d;
		io_dma = dma;
		prot_target = prot;
		lock_target = lock;
		#1 g_ok = guarded_wr_ok;
		@(negedge clk);
		io_wr = 1'b0;
		io_dma = 1'b0;
		prot_target = 1'b0;
		lock_target = 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(negedge clk);
		io_rd = 1'b1;
		io_addr = a;
		@(negedge clk);
		io_rd = 1'b0;
		chk(name, {24'h0, exp}, {24'h0, io_rdata_ff});
	endtask

	// one-cycle cpu event: mem_wr, retire, store, load, load_fuse, sleep
	task ev(input logic [5:0] v);
		@(negedge clk);
		{mem_wr, instr_retire, exec_store, exec_load, exec_load_fuse,
			exec_sleep} = v;
		#1 s_al = store_allow;
		l_al = load_allow;
		@(negedge clk);
		{mem_wr, instr_retire, exec_store, exec_load, exec_load_fuse,
			exec_sleep} = 6'h00;
	endtask

	task ww(input cpx_bidx_t b, input cpx_bidx_t top, input logic [7:0] d);
		@(negedge clk);
		wide_wr = 1'b1;
		wide_byte = b;
		wide_top = top;
		io_wdata = d;
		@(negedge clk);
		wide_wr = 1'b0;
	endtask

	// low byte then top byte on consecutive cycles, as a cpu would
	task ww16(input logic [7:0] lo, input logic [7:0] hi);
		@(negedge clk);
		wide_wr = 1'b1;
		wide_byte = 2'h0;
		wide_top = 2'h1;
		io_wdata = lo;
		@(negedge clk);
		wide_byte = 2'h1;
		io_wdata = hi;
		@(negedge clk);
		wide_wr = 1'b0;
	endtask

	task wrd(input cpx_bidx_t b, input logic [7:0] exp);
		@(negedge clk);
		wide_rd = 1'b1;
		wide_byte = b;
		wide_top = 2'h3;
		@(negedge clk);
		wide_rd = 1'b0;
		chk("wide read byte", {24'h0, exp}, {24'h0, io_rdata_ff});
	endtask

	initial begin
		#(25 * 5000);
		bad_count++;
		close_out();
	end

	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin
		{io_wr, io_rd, io_dma, mem_wr, instr_retire, exec_store} = 6'h00;
		{exec_load, exec_load_fuse, exec_sleep, prot_target} = 4'h0;
		{lock_target, fuse_lock, wide_rd, wide_wr} = 4'h0;
		io_addr = 8'h00;
		io_wdata = 8'h00;
		wide_byte = 2'h0;
		wide_top = 2'h1;
		wide_val = 32'h0;
		x_ptr = 16'h1234;
		y_ptr = 16'h5678;
		z_ptr = 16'h9ABC;
		direct_operand = 16'hDEF0;
		sys_rst = 1'b1;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		chk("irq hold after reset", 32'h0, {31'h0, irq_hold});
		for (int i = 0; i < 9; i++) rd(ofs[i], 8'h00, "reset value");
		wr(8'h13, 8'hAA, 1'b0, 1'b0, 1'b0);
		rd(8'h13, 8'h00, "unmapped read");
		for (int i = 0; i < 5; i++) begin
			wr(ofs[i + 1], ext_wv[i], 1'b0, 1'b0, 1'b0);
			rd(ofs[i + 1], ext_ev[i], "ext readback");
		end
		chk("x addr", {8'h00, 8'h02, x_ptr}, {8'h00, x_addr_ff});
		chk("y addr", {8'h00, 8'h03, y_ptr}, {8'h00, y_addr_ff});
		chk("z addr", {8'h00, 8'h0C, z_ptr}, {8'h00, z_addr_ff});
		chk("direct addr", {16'h0001, direct_operand},
			{8'h00, direct_addr_ff});
		chk("pm ext addr", {8'h00, 8'h0C, z_ptr},
			{8'h00, pm_ext_addr_ff});
		chk("pm load addr", {16'h0, z_ptr}, {8'h00, pm_load_addr_ff});
		chk("jump addr", {16'h0002, z_ptr}, {8'h00, jump_addr_ff});
		wr(`CPX_OFS_TMP1, 8'h5C, 1'b0, 1'b0, 1'b0);
		rd(`CPX_OFS_TMP1, 8'h5C, "temp direct");
		ww16(8'hA1, 8'hB2);
		chk("commit 16", 32'h1, {31'h0, wide_commit_ff});
		chk("wdata 16", 32'hB2A1, {16'h0, wide_wdata_ff[15:0]});
		ww(2'h0, 2'h3, 8'h11);
		ww(2'h1, 2'h3, 8'h22);
		ww(2'h2, 2'h3, 8'h33);
		chk("early commit", 32'h0, {31'h0, wide_commit_ff});
		ww(2'h3, 2'h3, 8'h44);
		chk("wdata 32", 32'h44332211, wide_wdata_ff);
		rd(`CPX_OFS_TMP2, 8'h33, "temp after wide");
		wide_val = 32'hDDCCBBAA;
		wrd(2'h0, 8'hAA);
		wide_val = 32'h0;
		wrd(2'h1, 8'hBB);
		wrd(2'h2, 8'hCC);
		wrd(2'h3, 8'hDD);
		wr(`CPX_OFS_KEY, 8'hD8, 1'b0, 1'b0, 1'b0);
		chk("irq hold io", 32'h1, {31'h0, irq_hold});
		rd(`CPX_OFS_KEY, 8'h01, "key io");
		wr(8'h40, 8'h01, 1'b0, 1'b1, 1'b0);
		chk("guarded ok", 32'h1, {31'h0, g_ok});
		chk("closed by write", 32'h0, {31'h0, irq_hold});
		wr(8'h40, 8'h01, 1'b0, 1'b1, 1'b0);
		chk("guarded shut", 32'h0, {31'h0, g_ok});
		wr(`CPX_OFS_KEY, 8'h55, 1'b0, 1'b0, 1'b0);
		rd(`CPX_OFS_KEY, 8'h00, "key wrong sig");
		wr(`CPX_OFS_KEY, 8'hD8, 1'b1, 1'b0, 1'b0);
		rd(`CPX_OFS_KEY, 8'h00, "key dma sig");
		wr(`CPX_OFS_KEY, 8'hD8, 1'b0, 1'b0, 1'b0);
		wr(`CPX_OFS_TMP0, 8'h77, 1'b1, 1'b0, 1'b0);
		repeat (3) ev(6'h10);
		chk("window three", 32'h1, {31'h0, irq_hold});
		ev(6'h10);
		chk("window four", 32'h0, {31'h0, irq_hold});
		rd(`CPX_OFS_TMP0, 8'h77, "dma temp write");
		fuse_lock = 1'b1;
		wr(`CPX_OFS_KEY, 8'hD8, 1'b0, 1'b0, 1'b0);
		wr(8'h40, 8'h01, 1'b0, 1'b1, 1'b1);
		chk("fuse lock", 32'h0, {31'h0, g_ok});
		fuse_lock = 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr(`CPX_OFS_KEY, 8'hD8, 1'b0, 1'b0, 1'b0);
			ev(io_cl[i]);
			chk("io close", 32'h0, {31'h0, irq_hold});
		end
		wr(`CPX_OFS_KEY, 8'h9D, 1'b0, 1'b0, 1'b0);
		rd(`CPX_OFS_KEY, 8'h02, "key pmem");
		ev(6'h08);
		chk("store allow", 32'h1, {31'h0, s_al});
		ev(6'h06);
		chk("fuse load allow", 32'h1, {31'h0, l_al});
		chk("pmem held", 32'h1, {31'h0, irq_hold});
		ev(6'h20);
		chk("pmem close mem", 32'h0, {31'h0, irq_hold});
		ev(6'h06);
		chk("fuse load shut", 32'h0, {31'h0, l_al});
		ev(6'h04);
		chk("plain load", 32'h1, {31'h0, l_al});
		ev(6'h08);
		chk("store shut", 32'h0, {31'h0, s_al});
		wr(`CPX_OFS_KEY, 8'h9D, 1'b0, 1'b0, 1'b0);
		ev(6'h01);
		chk("pmem close sleep", 32'h0, {31'h0, irq_hold});
		close_out();
	end
endmodule // testbench
